// ### core/magthr_defs.svh
// Register map, field positions, reset values and widths of the detector
`ifndef MAGTHR_DEFS_SVH
`define MAGTHR_DEFS_SVH

`define ADDR_CFG        8'h52
`define ADDR_SRC        8'h53
`define CFG_RESET       8'h00
`define CFG_LATCH_BIT   7
`define CFG_LOGIC_BIT   6
`define CFG_ZEN_BIT     5
`define CFG_YEN_BIT     4
`define CFG_XEN_BIT     3
`define CFG_WAKE_BIT    2
`define CFG_INTEN_BIT   1
`define CFG_PINSEL_BIT  0
`define SRC_ACTIVE_BIT  7
`define THS_WIDTH       15
`define SAMPLE_WIDTH    16
`define DBCNT_WIDTH     8

`endif

// ### core/magthr_pkg.sv
// Types shared by the magnetic threshold detector files
package magthr_pkg;
   typedef logic [7:0] reg8_t;
   typedef enum logic {
      COMBINE_AND_BELOW,
      COMBINE_OR_ABOVE
   } combine_t;
   typedef enum logic {
      DEBOUNCE_DECREMENT,
      DEBOUNCE_CLEAR
   } dbmode_t;
endpackage : magthr_pkg

// ### core/axis_compare.sv
// One axis: magnitude of a signed raw sample against its unsigned threshold
`timescale 1ns/100ps
module axis_compare #(
   parameter int SW = 16,
   parameter int TW = 15
) (
   input  wire logic          i_en,
   input  wire logic [SW-1:0] i_sample,
   input  wire logic [TW-1:0] i_ths,
   output logic               o_below,
   output logic               o_above,
   output logic               o_neg
);
   logic [SW-1:0] mag;
   logic [SW-1:0] ths_ext;

   // Absolute value; full-scale negative still fits since SW > TW
   always_comb begin
      mag     = i_sample[SW-1] ? SW'(~i_sample + 1'b1) : i_sample;
      ths_ext = SW'(i_ths);
      o_below = i_en && (mag <= ths_ext);
      o_above = i_en && (mag >= ths_ext);
      o_neg   = i_en && i_sample[SW-1];
   end
endmodule : axis_compare

// ### core/magnetic_threshold_detector.sv
// Magnetic threshold event detector with config and source registers
// Operation
// RQ1 - Select 0: all enabled axes at/below threshold
// RQ2 - Select 1: any enabled axis at/above threshold
// RQ3 - Flag only after debounce count reached
// RQ4 - Latch off: flag follows live detection
// RQ5 - Latch on: flag held until source read
// RQ6 - Axis enables Z,Y,X at bits 5,4,3
// RQ7 - Wake bit 2 routes flag to wake
// RQ8 - Interrupt enable bit 1 gates output
// RQ9 - Pin select 0 second pin, 1 first
// RQ10 - Unsigned 15-bit threshold per axis
// RQ11 - Compare raw samples before offset correction
// RQ12 - Config register resets to all zero
// RQ13 - Mode 1: counter cleared when false
// RQ14 - Mode 0: counter decremented when false
// RQ15 - Source bit 7 shows event active
// RQ16 - Per-axis event and sign, zero if disabled
// RQ17 - Counter steps once per output sample
// RQ18 - Compare magnitude, record sample sign
`timescale 1ns/100ps
`include "magthr_defs.svh"
module magnetic_threshold_detector #(
   parameter int SW = `SAMPLE_WIDTH,
   parameter int TW = `THS_WIDTH,
   parameter int CW = `DBCNT_WIDTH
) (
   input  wire logic                   I_CLK,
   input  wire logic                   I_RST_N,
   input  wire logic                   I_CE,
   input  wire logic [7:0]             I_REG_ADDR,
   input  wire logic                   I_REG_WR,
   input  wire logic                   I_REG_RD,
   input  wire magthr_pkg::reg8_t      I_REG_WDATA,
   output magthr_pkg::reg8_t           O_REG_RDATA,
   input  wire logic                   I_SAMPLE_VALID,
   input  wire logic [SW-1:0]          I_RAW_X,
   input  wire logic [SW-1:0]          I_RAW_Y,
   input  wire logic [SW-1:0]          I_RAW_Z,
   input  wire logic [TW-1:0]          I_THS_X,
   input  wire logic [TW-1:0]          I_THS_Y,
   input  wire logic [TW-1:0]          I_THS_Z,
   input  wire logic [CW-1:0]          I_DEBOUNCE_COUNT_SETTING,
   input  wire magthr_pkg::dbmode_t    I_DEBOUNCE_MODE,
   input  wire logic                   I_FIRST_INT_OTHER,
   input  wire logic                   I_SECOND_INT_OTHER,
   output logic                        O_EVENT_FLAG,
   output logic                        O_WAKE_SOURCE,
   output logic                        O_FIRST_INTERRUPT_PIN,
   output logic                        O_SECOND_INTERRUPT_PIN
);
   import magthr_pkg::*;

   reg8_t          cfg_q;
   reg8_t          rdata_q;
   logic [CW-1:0]  cnt_q;
   logic [CW-1:0]  cnt_d;
   logic           flag_q;
   logic [2:0]     axevt_q;
   logic [2:0]     axneg_q;
   logic [2:0]     en;
   logic [2:0]     below;
   logic [2:0]     above;
   logic [2:0]     neg;
   logic [2:0]     axhit;
   logic           cond;
   logic           hit;
   logic           src_rd;
   logic           th_int;
   combine_t       logic_sel;
   reg8_t          src_val;

   assign en = {cfg_q[`CFG_ZEN_BIT], cfg_q[`CFG_YEN_BIT],
                cfg_q[`CFG_XEN_BIT]};                          // RQ6
   assign logic_sel = combine_t'(cfg_q[`CFG_LOGIC_BIT]);
   assign src_rd = I_CE && I_REG_RD && (I_REG_ADDR == `ADDR_SRC);

   // Raw samples go straight in; the offset path is elsewhere  RQ11
   axis_compare #(.SW(SW), .TW(TW)) u_cmp_x (
      .i_en(en[0]), .i_sample(I_RAW_X), .i_ths(I_THS_X),      // RQ10
      .o_below(below[0]), .o_above(above[0]), .o_neg(neg[0]));
   axis_compare #(.SW(SW), .TW(TW)) u_cmp_y (
      .i_en(en[1]), .i_sample(I_RAW_Y), .i_ths(I_THS_Y),
      .o_below(below[1]), .o_above(above[1]), .o_neg(neg[1]));
   axis_compare #(.SW(SW), .TW(TW)) u_cmp_z (
      .i_en(en[2]), .i_sample(I_RAW_Z), .i_ths(I_THS_Z),
      .o_below(below[2]), .o_above(above[2]), .o_neg(neg[2]));

   // Combine axes; with no axis enabled nothing is ever detected
   always_comb begin
      case (logic_sel)
         COMBINE_AND_BELOW: begin
            axhit = below;
            cond  = (en != 3'h0) && ((below | ~en) == 3'h7);   // RQ1
         end
         COMBINE_OR_ABOVE: begin
            axhit = above;
            cond  = |above;                                    // RQ2
         end
         default: begin
            axhit = 3'h0;
            cond  = 1'b0;
         end
      endcase
   end

   // Debounce counter saturates at the programmed count
   always_comb begin
      if (cond) begin
         cnt_d = (cnt_q >= I_DEBOUNCE_COUNT_SETTING) ?
                 I_DEBOUNCE_COUNT_SETTING : CW'(cnt_q + 1'b1);  // RQ17
      end else if (I_DEBOUNCE_MODE == DEBOUNCE_CLEAR) begin
         cnt_d = '0;                                           // RQ13
      end else begin
         cnt_d = (cnt_q == '0) ? '0 : CW'(cnt_q - 1'b1);       // RQ14
      end
      hit = cond && (cnt_d >= I_DEBOUNCE_COUNT_SETTING);       // RQ3
   end

   // Counter steps only on a delivered output sample
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cnt_q <= '0;
      end else if (I_CE && I_SAMPLE_VALID) begin
         cnt_q <= cnt_d;                                       // RQ17
      end
   end

   // Configuration register
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cfg_q <= `CFG_RESET;                                  // RQ12
      end else if (I_CE && I_REG_WR && I_REG_ADDR == `ADDR_CFG) begin
         cfg_q <= I_REG_WDATA;
      end
   end

   // Event flag and per-axis capture; a new hit beats a clearing read
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flag_q  <= 1'b0;
         axevt_q <= 3'h0;
         axneg_q <= 3'h0;
      end else if (I_CE) begin
         if (!cfg_q[`CFG_LATCH_BIT]) begin
            if (I_SAMPLE_VALID) begin
               flag_q  <= hit;                                 // RQ4
               axevt_q <= hit ? axhit : 3'h0;
               axneg_q <= hit ? (neg & axhit) : 3'h0;          // RQ18
            end
         end else if (I_SAMPLE_VALID && hit) begin
            flag_q  <= 1'b1;                                   // RQ5
            axevt_q <= (src_rd ? 3'h0 : axevt_q) | axhit;
            axneg_q <= (src_rd ? 3'h0 : axneg_q) | (neg & axhit);
         end else if (src_rd) begin
            flag_q  <= 1'b0;                                   // RQ5
            axevt_q <= 3'h0;
            axneg_q <= 3'h0;
         end
      end
   end

   // Source view; disabled axes are masked at read time
   always_comb begin
      src_val = 8'h00;
      src_val[`SRC_ACTIVE_BIT] = flag_q;                       // RQ15
      for (int i = 0; i < 3; i++) begin
         src_val[2*i+1] = axevt_q[i] & en[i];                  // RQ16
         src_val[2*i]   = axneg_q[i] & en[i];                  // RQ16
      end
   end

   // Read data registered; unmapped addresses read zero
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rdata_q <= 8'h00;
      end else if (I_CE && I_REG_RD) begin
         case (I_REG_ADDR)
            `ADDR_CFG: rdata_q <= cfg_q;
            `ADDR_SRC: rdata_q <= src_val;
            default:   rdata_q <= 8'h00;
         endcase
      end
   end

   // Interrupt routing and wake participation
   assign th_int = flag_q && cfg_q[`CFG_INTEN_BIT];            // RQ8
   assign O_FIRST_INTERRUPT_PIN = I_FIRST_INT_OTHER ||
          (th_int && cfg_q[`CFG_PINSEL_BIT]);                  // RQ9
   assign O_SECOND_INTERRUPT_PIN = I_SECOND_INT_OTHER ||
          (th_int && !cfg_q[`CFG_PINSEL_BIT]);                 // RQ9
   assign O_WAKE_SOURCE = flag_q && cfg_q[`CFG_WAKE_BIT];      // RQ7
   assign O_EVENT_FLAG  = flag_q;
   assign O_REG_RDATA   = rdata_q;

   default clocking dc @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   AST_AND_NEEDS_ALL: assert property (I_CE && I_SAMPLE_VALID && // RQ1
      !cfg_q[`CFG_LATCH_BIT] && logic_sel == COMBINE_AND_BELOW &&
      en[0] && !below[0] |=> !flag_q)
      else $error("AND mode flagged with X above threshold");
   // Counts of 0 and 1 both flag on the first true sample
   AST_OR_ANY: assert property (I_CE && I_SAMPLE_VALID && // RQ2
      logic_sel == COMBINE_OR_ABOVE && I_DEBOUNCE_COUNT_SETTING <= CW'(1) &&
      (above != 3'h0) |=> flag_q)
      else $error("OR mode missed an axis above threshold");
   AST_DEBOUNCE: assert property (I_CE && I_SAMPLE_VALID && !flag_q && // RQ3
      cnt_d < I_DEBOUNCE_COUNT_SETTING |=> !flag_q)
      else $error("Flag set before debounce count");
   AST_FOLLOW: assert property (I_CE && I_SAMPLE_VALID && // RQ4
      !cfg_q[`CFG_LATCH_BIT] |=> flag_q == $past(hit))
      else $error("Unlatched flag does not follow detection");
   AST_LATCH_HOLD: assert property (flag_q && cfg_q[`CFG_LATCH_BIT] && // RQ5
      !src_rd |=> flag_q)
      else $error("Latched flag dropped without read");
   AST_CLEAR_MODE: assert property (I_CE && I_SAMPLE_VALID && !cond && // RQ13
      I_DEBOUNCE_MODE == DEBOUNCE_CLEAR |=> cnt_q == '0)
      else $error("Counter not cleared");
   AST_DEC_MODE: assert property (I_CE && I_SAMPLE_VALID && !cond && // RQ14
      I_DEBOUNCE_MODE == DEBOUNCE_DECREMENT && cnt_q != '0
      |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("Counter not decremented");
   AST_INT_GATE: assert property (!cfg_q[`CFG_INTEN_BIT] && // RQ8
      !I_FIRST_INT_OTHER |-> !O_FIRST_INTERRUPT_PIN)
      else $error("Interrupt leaked while disabled");
   AST_SRC_MASK: assert property (I_CE && I_REG_RD && // RQ16
      I_REG_ADDR == `ADDR_SRC && !en[0] |=> O_REG_RDATA[1:0] == 2'h0)
      else $error("Disabled X axis bits read nonzero");
   // Checked through the register path, not against its own expression
   AST_WAKE: assert property (I_CE && I_REG_WR && // RQ7
      I_REG_ADDR == `ADDR_CFG && !I_REG_WDATA[`CFG_WAKE_BIT]
      |=> !O_WAKE_SOURCE)
      else $error("Wake source left on after disable write");

   COV_LATCH_SET: cover property (cfg_q[`CFG_LATCH_BIT] && $rose(flag_q));
   COV_READ_CLR: cover property (flag_q && src_rd ##1 !flag_q);
   COV_OR_EVT: cover property (logic_sel == COMBINE_OR_ABOVE && $rose(flag_q));
   COV_SECOND_INTERRUPT_PIN: cover property (th_int && !cfg_q[`CFG_PINSEL_BIT]);
endmodule : magnetic_threshold_detector

// ### verif/mag_host_model.sv
// Host processor model: register write and read cycles toward the detector
`timescale 1ns/100ps
module mag_host_model (
   input  wire logic              i_clk,
   input  wire magthr_pkg::reg8_t i_rdata,
   output logic [7:0]             o_addr,
   output logic                   o_wr,
   output logic                   o_rd,
   output magthr_pkg::reg8_t      o_wdata
);
   import magthr_pkg::*;
   // Strobes idle from time zero so no request lands during reset
   initial begin
      o_addr  = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_wdata = 8'h00;
   end
   // One-cycle write strobe; data inverted after release so stale data
   // can never pass for a held value
   task automatic wr(input logic [7:0] a, input reg8_t d);
      @(negedge i_clk);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clk);
      o_wr    = 1'b0;
      o_wdata = ~d;
   endtask : wr
   // One-cycle read strobe, data taken a full cycle later
   task automatic rd(input logic [7:0] a, output reg8_t d);
      @(negedge i_clk);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clk);
      o_rd   = 1'b0;
      @(negedge i_clk);
      d = i_rdata;
   endtask : rd
endmodule : mag_host_model

// ### verif/magnetic_threshold_detector_tb_top.sv
// Self-checking bench for the magnetic threshold detector
`timescale 1ns/100ps
`include "magthr_defs.svh"
module magnetic_threshold_detector_tb_top;
   import magthr_pkg::*;
   logic        clk, rst_n, valid, oth1, oth2, wr, rd, flag, wake;
   logic        pin1, pin2, ce;
   logic [15:0] raw [3];
   logic [14:0] ths [3];
   logic [7:0]  cnt_set, addr;
   dbmode_t     mode;
   reg8_t       rdata, wdata, cfg, got, exp;
   int          fail_count, checks_done;
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   mag_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
      .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   magnetic_threshold_detector uut (.I_CLK(clk), .I_RST_N(rst_n),
      .I_CE(ce), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd),
      .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_SAMPLE_VALID(valid),
      .I_RAW_X(raw[0]), .I_RAW_Y(raw[1]), .I_RAW_Z(raw[2]),
      .I_THS_X(ths[0]), .I_THS_Y(ths[1]), .I_THS_Z(ths[2]),
      .I_DEBOUNCE_COUNT_SETTING(cnt_set), .I_DEBOUNCE_MODE(mode),
      .I_FIRST_INT_OTHER(oth1), .I_SECOND_INT_OTHER(oth2),
      .O_EVENT_FLAG(flag), .O_WAKE_SOURCE(wake),
      .O_FIRST_INTERRUPT_PIN(pin1), .O_SECOND_INTERRUPT_PIN(pin2));
   // Compare and count
   task automatic check(input string what, input logic [7:0] seen, e);
      checks_done++;
      if (seen !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
      end
   endtask : check
   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   // Expected source byte of one sample; zero when no event is detected
   function automatic reg8_t expect_src(input reg8_t c);
      logic [16:0] m;
      logic [2:0]  hit;
      reg8_t       s;
      s = 8'h00;
      for (int i = 0; i < 3; i++) begin
         m = raw[i][15] ? 17'h10000 - {1'b0, raw[i]} : {1'b0, raw[i]};
         hit[i] = c[3+i] & (c[6] ? m >= ths[i] : m <= ths[i]);
         s[2*i+1] = hit[i];
         s[2*i] = hit[i] & raw[i][15];
      end
      // AND mode needs every enabled axis and at least one enabled
      if (c[6] ? |hit : (hit == c[5:3] && |c[5:3])) s[7] = 1'b1;
      else s = 8'h00;
      return s;
   endfunction : expect_src
   // One sample pulse, then one settled cycle before looking
   task automatic sample(input logic [15:0] x, y, z);
      @(negedge clk);
      raw = '{x, y, z};
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
   endtask : sample
   // Flag, wake and both pins against one expected flag value
   task automatic pins(input reg8_t c, input logic f);
      check("flag", flag, f);
      check("wake", wake, f & c[2]);
      check("pin1", pin1, oth1 | (f & c[1] & c[0]));
      check("pin2", pin2, oth2 | (f & c[1] & ~c[0]));
   endtask : pins
   // Hang guard, far beyond the expected 1300 or so cycles
   initial begin
      #500000;
      fail_count++;
      results();
   end
   // Test sequence
   initial begin
      void'($urandom(21006));
      {rst_n, valid, oth1, oth2, cnt_set} = '0;
      ce = 1'b1;
      mode = DEBOUNCE_CLEAR;
      raw = '{16'h0000, 16'h0000, 16'h0000};
      ths = '{15'h0000, 15'h0000, 15'h0000};
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      host.rd(`ADDR_CFG, got);
      check("cfg reset", got, `CFG_RESET);
      pins(8'h00, 1'b0);
      host.wr(`ADDR_CFG, 8'hA5);
      host.wr(`ADDR_SRC, 8'h5A);
      host.rd(`ADDR_CFG, got);
      check("cfg rw", got, 8'hA5);
      host.rd(8'h60, got);
      check("unmapped", got, 8'h00);
      $display("test registers done");
      // Random config and samples, latch off, flag on first hit
      for (int n = 0; n < 200; n++) begin
         cfg = 8'($urandom) & 8'h7F;
         // Count of 0 or 1: both must flag on the first true sample
         cnt_set = {7'h00, 1'($urandom)};
         ths = '{15'($urandom), 15'($urandom), 15'($urandom)};
         {oth1, oth2} = 2'($urandom);
         host.wr(`ADDR_CFG, cfg);
         // Early rounds put each sample exactly on its threshold
         if (n < 8) sample({1'b0, ths[0]}, {1'b0, ths[1]}, {1'b0, ths[2]});
         else sample(16'($urandom), 16'($urandom), 16'($urandom));
         exp = expect_src(cfg);
         pins(cfg, exp[7]);
         if (n % 4 == 0) begin
            host.rd(`ADDR_SRC, got);
            check("source", got, exp);
         end
      end
      $display("test random done");
      // Debounce of 3 with a gap: true,true,false,true,true,true
      {oth1, oth2} = 2'b00;
      cnt_set = 8'h03;
      ths[0] = 15'h0064;
      host.wr(`ADDR_CFG, 8'h4A);
      for (int md = 0; md < 2; md++) begin
         mode = dbmode_t'(md);
         exp = md ? 8'h20 : 8'h30;
         repeat (3) sample(16'h0000, 16'h0000, 16'h0000);
         for (int k = 0; k < 6; k++) begin
            sample(k == 2 ? 16'h0000 : 16'h7FFF, 16'h0000, 16'h0000);
            check("debounce", flag, exp[k]);
         end
      end
      $display("test debounce done");
      // Latched negative X hit held over a quiet sample, cleared by read
      cnt_set = 8'h01;
      host.wr(`ADDR_CFG, 8'hCB);
      sample(16'hFF38, 16'h0000, 16'h0000);
      sample(16'h0000, 16'h0000, 16'h0000);
      pins(8'hCB, 1'b1);
      host.rd(`ADDR_SRC, got);
      check("latched source", got, 8'h83);
      pins(8'hCB, 1'b0);
      // New latched hit, then a read that meets another hit: set wins
      sample(16'h00C8, 16'h0000, 16'h0000);
      pins(8'hCB, 1'b1);
      fork
         host.rd(`ADDR_SRC, got);
         sample(16'hFF00, 16'h0000, 16'h0000);
      join
      check("read with hit", got, 8'h82);
      pins(8'hCB, 1'b1);
      host.rd(`ADDR_SRC, got);
      check("hit kept", got, 8'h83);
      $display("test latch done");
      // Mid-run reset: flag up first, then config and flag wiped
      sample(16'h00C8, 16'h0000, 16'h0000);
      {oth1, oth2} = 2'b10;
      pins(8'hCB, 1'b1);
      rst_n = 1'b0;
      @(negedge clk);
      pins(8'h00, 1'b0);
      rst_n = 1'b1;
      host.rd(`ADDR_CFG, got);
      check("cfg after reset", got, `CFG_RESET);
      $display("test reset done");
      // Clock enable low freezes the register bus and the sample path
      host.wr(`ADDR_CFG, 8'h4A);
      ce = 1'b0;
      sample(16'h00C8, 16'h0000, 16'h0000);
      host.wr(`ADDR_CFG, 8'h00);
      check("frozen flag", flag, 1'b0);
      ce = 1'b1;
      host.rd(`ADDR_CFG, got);
      check("frozen cfg", got, 8'h4A);
      sample(16'h00C8, 16'h0000, 16'h0000);
      check("thawed flag", flag, 1'b1);
      $display("test enable done");
      results();
   end
endmodule : magnetic_threshold_detector_tb_top
